// ### bha_pkg.sv
package bha_pkg;

    // ------------------------------------------------------------
    // Arbiter states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        st_idle,
        st_give_a,
        st_give_b,
        st_rearb_b,
        st_rearb_a,
        st_own_a,
        st_own_b
    } bha_state_t;

    localparam int BHA_NUM_STATES = 7;

    // ------------------------------------------------------------
    // Output vector layout
    // ------------------------------------------------------------
    localparam int BHA_OUT_W = 9;
    localparam int BHA_POS_HANDOVER = 8;
    localparam int BHA_POS_RELEASE = 7;
    localparam int BHA_POS_FLAGS = 0;

    // Outputs while held in reset: idle, processor owns the bus
    localparam logic [BHA_OUT_W-1:0] BHA_OUT_RESET = 9'h001;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int BHA_CLK_HZ = 10_000_000;
    localparam int BHA_STEP_NS = 40;
    localparam int BHA_CLK_NS = 1_000_000_000 / BHA_CLK_HZ;
    // Clocks per arbiter step, rounded down, at least one
    localparam int BHA_STEP_CYC =
        (BHA_STEP_NS / BHA_CLK_NS) < 1 ? 1 : (BHA_STEP_NS / BHA_CLK_NS);

endpackage

// ### bha_out_decode.sv
module bha_out_decode
    import bha_pkg::*;
(
    // State in
    input wire bha_pkg::bha_state_t state,
    // Decoded outputs
    output logic [bha_pkg::BHA_OUT_W-1:0] outs
);
    import bha_pkg::*;

    always_comb begin
        outs = '0;
        // One-hot flag per state; enum order matches flag order
        for (int i = 0; i < BHA_NUM_STATES; i++) begin
            outs[BHA_POS_FLAGS + i] = (int'(state) == i);
        end
        case (state)
            st_idle: begin
                outs[BHA_POS_HANDOVER] = 1'b0;
                outs[BHA_POS_RELEASE] = 1'b0;
            end
            st_give_a, st_give_b, st_rearb_a, st_rearb_b: begin
                outs[BHA_POS_HANDOVER] = 1'b1;
                outs[BHA_POS_RELEASE] = 1'b1;
            end
            default: begin
                outs[BHA_POS_HANDOVER] = 1'b0;
                outs[BHA_POS_RELEASE] = 1'b1;
            end
        endcase
    end

endmodule

// ### bha_arbiter.sv
// Behaviour
// - Reset leaves the arbiter idle with the processor owning the bus.
// - Handover and release levels are fixed per state.
// - Seven one-hot flags show the current state.
// - Idle: want without owns gives grant; owns goes own_a; else stay.
// - give_b: owns, or both low, goes own_b; else stay.
// - rearb_b: no want goes own_b; want without owns goes give_b.
// - own_a: want goes rearb_a; both low goes idle; else stay.
// - give_a, rearb_a and own_b advance unconditionally after one step.
// - Overlapping branch conditions resolve to the earliest listed.
// - Transitions are evaluated once per arbiter step of STEP_CYC clocks; the 40 ns default rounds down to zero and is raised to one 100 ns clock.
// - Outputs are registered and depend on the current state alone.
module bha_arbiter
    import bha_pkg::*;
#(
    parameter int STEP_CYC = BHA_STEP_CYC
)
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Master handshake, synchronous to sys_clk
    input wire logic master_bus_want,
    input wire logic master_owns_bus,
    // Handover control
    output logic handover_pulse,
    output logic cpu_bus_release,
    // State indicators
    output logic flag_idle,
    output logic flag_give_a,
    output logic flag_give_b,
    output logic flag_rearb_b,
    output logic flag_rearb_a,
    output logic flag_own_a,
    output logic flag_own_b
);
    import bha_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        bha_state_t state;
        logic [7:0] div;
        logic [BHA_OUT_W-1:0] outs;
    } bha_regs_t;

    localparam logic [7:0] DIV_LAST = 8'(STEP_CYC - 1);

    bha_regs_t s_reg;
    bha_regs_t s_next;
    logic step;
    bha_state_t nxt_state;
    logic [BHA_OUT_W-1:0] nxt_outs;

    // ------------------------------------------------------------
    // Step enable
    // ------------------------------------------------------------
    // One enable pulse per arbiter step; the state only moves on it
    assign step = (s_reg.div == DIV_LAST);

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    // If/else chains give priority by order, and the trailing
    // default needs no negated term.
    always_comb begin
        nxt_state = s_reg.state;
        case (s_reg.state)
            st_idle: begin
                if (master_bus_want && !master_owns_bus) begin
                    nxt_state = st_give_a;
                end else if (master_owns_bus) begin
                    nxt_state = st_own_a;
                end else begin
                    nxt_state = st_idle;
                end
            end
            st_give_a: begin
                nxt_state = st_give_b;
            end
            st_give_b: begin
                if (master_owns_bus
                    || (!master_bus_want && !master_owns_bus)) begin
                    nxt_state = st_own_b;
                end else begin
                    nxt_state = st_give_b;
                end
            end
            st_rearb_b: begin
                if (!master_bus_want) begin
                    nxt_state = st_own_b;
                end else if (master_bus_want && !master_owns_bus) begin
                    nxt_state = st_give_b;
                end else begin
                    nxt_state = st_rearb_b;
                end
            end
            st_rearb_a: begin
                nxt_state = st_rearb_b;
            end
            st_own_a: begin
                if (master_bus_want) begin
                    nxt_state = st_rearb_a;
                end else if (!master_bus_want && !master_owns_bus) begin
                    nxt_state = st_idle;
                end else begin
                    nxt_state = st_own_a;
                end
            end
            st_own_b: begin
                nxt_state = st_own_a;
            end
            default: begin
                nxt_state = st_idle;
            end
        endcase
    end

    // Outputs are decoded from the next state and registered with it,
    // so every pin is a flop that matches the current state.
    bha_out_decode u_dec (
        .state(nxt_state),
        .outs(nxt_outs)
    );

    always_comb begin
        s_next = s_reg;
        s_next.div = step ? 8'h00 : s_reg.div + 8'h01;
        if (step) begin
            s_next.state = nxt_state;
            s_next.outs = nxt_outs;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            s_reg.state <= st_idle;
            s_reg.div <= 8'h00;
            s_reg.outs <= BHA_OUT_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    // ------------------------------------------------------------
    // Output pins
    // ------------------------------------------------------------
    assign handover_pulse = s_reg.outs[BHA_POS_HANDOVER];
    assign cpu_bus_release = s_reg.outs[BHA_POS_RELEASE];
    assign flag_idle = s_reg.outs[BHA_POS_FLAGS + 0];
    assign flag_give_a = s_reg.outs[BHA_POS_FLAGS + 1];
    assign flag_give_b = s_reg.outs[BHA_POS_FLAGS + 2];
    assign flag_rearb_b = s_reg.outs[BHA_POS_FLAGS + 3];
    assign flag_rearb_a = s_reg.outs[BHA_POS_FLAGS + 4];
    assign flag_own_a = s_reg.outs[BHA_POS_FLAGS + 5];
    assign flag_own_b = s_reg.outs[BHA_POS_FLAGS + 6];

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_reset_idle;
        @(posedge sys_clk) !rstn |=> flag_idle && !cpu_bus_release;
    endproperty
    a_reset_idle: assert property (p_reset_idle)
        else $error("not idle after reset");

    property p_idle_levels;
        @(posedge sys_clk) disable iff (!rstn)
            flag_idle |-> !handover_pulse && !cpu_bus_release;
    endproperty
    a_idle_levels: assert property (p_idle_levels)
        else $error("idle drives handover or release");

    property p_own_levels;
        @(posedge sys_clk) disable iff (!rstn)
            (flag_own_a || flag_own_b) |-> !handover_pulse && cpu_bus_release;
    endproperty
    a_own_levels: assert property (p_own_levels)
        else $error("own state levels wrong");

    property p_onehot;
        @(posedge sys_clk) disable iff (!rstn)
            $onehot({flag_idle, flag_give_a, flag_give_b, flag_rearb_b,
                     flag_rearb_a, flag_own_a, flag_own_b});
    endproperty
    a_onehot: assert property (p_onehot)
        else $error("state flags not one-hot");

    property p_idle_grant;
        @(posedge sys_clk) disable iff (!rstn)
            step && flag_idle && master_bus_want && !master_owns_bus
            |=> flag_give_a && handover_pulse;
    endproperty
    a_idle_grant: assert property (p_idle_grant)
        else $error("idle did not start handover");

    property p_give_b_exit;
        @(posedge sys_clk) disable iff (!rstn)
            step && flag_give_b && master_owns_bus |=> flag_own_b;
    endproperty
    a_give_b_exit: assert property (p_give_b_exit)
        else $error("give_b did not go to own_b");

    property p_rearb_b_prio;
        @(posedge sys_clk) disable iff (!rstn)
            step && flag_rearb_b && !master_bus_want |=> flag_own_b;
    endproperty
    a_rearb_b_prio: assert property (p_rearb_b_prio)
        else $error("rearb_b did not go to own_b");

    property p_own_a_prio;
        @(posedge sys_clk) disable iff (!rstn)
            step && flag_own_a && master_bus_want && master_owns_bus
            |=> flag_rearb_a;
    endproperty
    a_own_a_prio: assert property (p_own_a_prio)
        else $error("own_a ignored want");

    property p_give_a_step;
        @(posedge sys_clk) disable iff (!rstn)
            step && flag_give_a |=> flag_give_b;
    endproperty
    a_give_a_step: assert property (p_give_a_step)
        else $error("give_a did not advance");

    property p_hold_between;
        @(posedge sys_clk) disable iff (!rstn)
            !$stable(s_reg.outs) |-> $past(step) || !$past(rstn);
    endproperty
    a_hold_between: assert property (p_hold_between)
        else $error("outputs moved between steps");

endmodule

// ### bha_master_model.sv
module bha_master_model (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Bench control
    input wire logic start,
    input wire logic [3:0] wait_cyc,
    input wire logic [3:0] hold_cyc,
    output logic busy,
    // Arbiter side
    input wire logic handover_pulse,
    output logic want,
    output logic owns
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [1:0] ph_reg;
    logic [3:0] cnt_reg;

    assign busy = (ph_reg != 2'h0);

    // Falling edge, so the arbiter always samples settled levels
    always @(negedge sys_clk) begin
        if (!rstn) begin
            want <= 1'b0;
            owns <= 1'b0;
            ph_reg <= 2'h0;
            cnt_reg <= 4'h0;
        end else begin
            case (ph_reg)
                2'h0: if (start) begin
                    want <= 1'b1;
                    ph_reg <= 2'h1;
                end
                2'h1: if (handover_pulse) begin
                    cnt_reg <= wait_cyc;
                    ph_reg <= 2'h2;
                end
                // A long wait keeps the arbiter parked in the grant
                2'h2: if (cnt_reg == 4'h0) begin
                    owns <= 1'b1;
                    want <= 1'b0;
                    cnt_reg <= hold_cyc;
                    ph_reg <= 2'h3;
                end else begin
                    cnt_reg <= cnt_reg - 4'h1;
                end
                default: if (cnt_reg == 4'h0) begin
                    owns <= 1'b0;
                    ph_reg <= 2'h0;
                end else begin
                    cnt_reg <= cnt_reg - 4'h1;
                end
            endcase
        end
    end
endmodule

// ### test_bus_handover_arbiter.sv
module test_bus_handover_arbiter import bha_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;

    logic sys_clk, rstn, r_want, r_owns, use_model, start, chk;
    logic m_want, m_owns, busy, want, owns, hand, rel;
    logic [3:0] wait_cyc, hold_cyc;
    wire [6:0] flags;
    logic [6:0] seen;
    logic [8:0] exp_v;
    logic [31:0] seed;
    bha_state_t ref_st;
    int num_errors, tests_run, i, n;

    assign want = use_model ? m_want : r_want;
    assign owns = use_model ? m_owns : r_owns;

    bha_arbiter #(.STEP_CYC(1)) DUT (
        .sys_clk(sys_clk), .rstn(rstn),
        .master_bus_want(want), .master_owns_bus(owns),
        .handover_pulse(hand), .cpu_bus_release(rel),
        .flag_idle(flags[0]), .flag_give_a(flags[1]),
        .flag_give_b(flags[2]), .flag_rearb_b(flags[3]),
        .flag_rearb_a(flags[4]), .flag_own_a(flags[5]),
        .flag_own_b(flags[6])
    );

    bha_master_model u_master (
        .sys_clk(sys_clk), .rstn(rstn), .start(start),
        .wait_cyc(wait_cyc), .hold_cyc(hold_cyc), .busy(busy),
        .handover_pulse(hand), .want(m_want), .owns(m_owns)
    );

    // ------------------------------------------------------------
    // Expectations
    // ------------------------------------------------------------
    function automatic bha_state_t next_st(bha_state_t s, logic w, logic o);
        case (s)
            st_idle: return (w && !o) ? st_give_a : (o ? st_own_a : s);
            st_give_a: return st_give_b;
            st_give_b: return (o || !w) ? st_own_b : s;
            st_rearb_b: return !w ? st_own_b : (!o ? st_give_b : s);
            st_rearb_a: return st_rearb_b;
            st_own_a: return w ? st_rearb_a : (!o ? st_idle : s);
            default: return st_own_a;
        endcase
    endfunction

    function automatic logic [8:0] exp_out(bha_state_t s);
        logic h;
        h = s inside {st_give_a, st_give_b, st_rearb_a, st_rearb_b};
        return {h, s != st_idle, 7'h01 << s};
    endfunction

    function automatic logic [31:0] xs(logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction

    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Clock, reference state and per-cycle compare
    // ------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        ref_st <= !rstn ? st_idle : next_st(ref_st, want, owns);
    end

    always @(negedge sys_clk) begin
        if (chk) begin
            tests_run += 2;
            exp_v = exp_out(ref_st);
            if ({hand, rel} !== exp_v[8:7]) begin
                num_errors++;
                $display("unexpected at %0t: handover %b release %b",
                         $time, hand, rel);
            end
            if (flags !== exp_v[6:0]) begin
                num_errors++;
                $display("unexpected at %0t: flags %h", $time, flags);
            end
            seen <= seen | flags;
        end
    end

    // ------------------------------------------------------------
    // Stimulus
    // ------------------------------------------------------------
    initial begin
        rstn = 1'b0;
        r_want = 1'b0;
        r_owns = 1'b0;
        use_model = 1'b0;
        start = 1'b0;
        wait_cyc = 4'h0;
        hold_cyc = 4'h0;
        seed = 32'ha3185452;
        seen = 7'h00;
        chk = 1'b0;
        num_errors = 0;
        tests_run = 0;
        @(posedge sys_clk);
        chk = 1'b1;
        repeat (4) @(posedge sys_clk);
        @(negedge sys_clk);
        rstn <= 1'b1;
        $display("reset test done");
        // Random levels, both-high overlaps and rare mid-run resets
        repeat (2000) begin
            @(negedge sys_clk);
            seed = xs(seed);
            r_want <= seed[0];
            r_owns <= seed[5];
            rstn <= (seed[15:8] != 8'h00);
        end
        $display("random test done");
        // Master model answers from prompt to slow
        for (n = 0; n < 4; n++) begin
            @(negedge sys_clk);
            use_model <= 1'b1;
            rstn <= 1'b1;
            wait_cyc <= 4'(n * 3);
            hold_cyc <= 4'(7 - n * 2);
            start <= 1'b1;
            repeat (2) @(negedge sys_clk);
            start <= 1'b0;
            for (i = 0; i < 60 && (busy || !flags[0]); i++) begin
                @(negedge sys_clk);
            end
            if (i == 60) begin
                num_errors++;
                $display("unexpected at %0t: handover hung", $time);
                results();
            end
            $display("handover test %0d done", n);
        end
        tests_run++;
        if (seen !== 7'h7f) begin
            num_errors++;
            $display("unexpected at %0t: states seen %h", $time, seen);
        end
        results();
    end
endmodule
